// ===== src/fpis_pkg.sv
// Package with encodings, field positions and register map of the insert/subtract slice.
package fpis_pkg;
  // Instruction field positions, numbered with bit 0 as the most significant bit.
  localparam int unsigned OPCD_HI        = 0;
  localparam int unsigned OPCD_LO        = 5;
  localparam int unsigned XO_HI          = 21;
  localparam int unsigned XO_LO          = 30;
  localparam int unsigned REC_POS        = 31;
  localparam int unsigned AMT_HI         = 27;
  localparam int unsigned AMT_LO         = 31;
  // Opcode values.
  localparam logic [5:0]  OPC_EXT        = 6'h1f;
  localparam logic [9:0]  XO_INSERT_BIT  = 10'h219;
  localparam logic [5:0]  OPC_SUBI       = 6'h0c;
  localparam logic [5:0]  OPC_SUBI_REC   = 6'h0d;
  // Wishbone register map, byte addresses.
  localparam logic [3:0]  ADDR_INSN      = 4'h0;
  localparam logic [3:0]  ADDR_SRC       = 4'h4;
  localparam logic [3:0]  ADDR_AMT       = 4'h8;
  localparam logic [3:0]  ADDR_RESULT    = 4'hc;
  localparam logic [3:0]  ADDR_STATUS    = 4'h0;
  // Status word bit positions (little-endian numbering on the bus).
  localparam int unsigned ST_SO          = 0;
  localparam int unsigned ST_EQ          = 1;
  localparam int unsigned ST_GT          = 2;
  localparam int unsigned ST_LT          = 3;
  localparam int unsigned ST_CA          = 4;
  localparam int unsigned ST_WE          = 5;
  localparam int unsigned ST_CRWE        = 6;
  localparam int unsigned ST_CAWE        = 7;
  localparam int unsigned ST_ILL         = 8;
  localparam logic [31:0] RESET_WORD     = 32'h0000_0000;
  typedef enum logic [1:0] {
    FPIS_OP_NONE = 2'b00,
    FPIS_OP_INS  = 2'b01,
    FPIS_OP_SUB  = 2'b10,
    FPIS_OP_SUBR = 2'b11
  } fpis_op_e;
endpackage

// ===== src/fpis_exec.sv
// Combinational execute stage for the insert-bit and immediate subtract operations.
`timescale 1ns/100ps
`default_nettype none
module fpis_exec (
  input  wire logic [31:0]      insn_i,
  input  wire logic [31:0]      src_i,
  input  wire logic [31:0]      amt_i,
  input  wire logic [31:0]      tgt_i,
  input  wire logic             so_i,
  output var fpis_pkg::fpis_op_e op_o,
  output logic      [31:0]      result_o,
  output logic                  carry_o,
  output logic      [3:0]       cr0_o,
  output logic                  rec_o
);
  logic [5:0]  opcd;
  logic [9:0]  xo;
  logic [4:0]  amount;
  logic [31:0] imm_ext;
  logic [32:0] sum;

  // Bit 0 of the documented numbering is bit 31 here, so fields are reversed ranges.
  assign opcd    = insn_i[31-fpis_pkg::OPCD_HI -: 6];
  assign xo      = insn_i[31-fpis_pkg::XO_HI -: 10];
  assign amount  = amt_i[31-fpis_pkg::AMT_HI -: 5];
  assign imm_ext = {{16{insn_i[15]}}, insn_i[15:0]};
  assign sum     = {1'b0, tgt_i} + {1'b0, imm_ext};
  assign rec_o   = insn_i[31-fpis_pkg::REC_POS];

  // Operation decode; anything else is left to other slices.
  always_comb begin
    op_o = fpis_pkg::FPIS_OP_NONE;
    if (opcd == fpis_pkg::OPC_EXT && xo == fpis_pkg::XO_INSERT_BIT) begin
      op_o = fpis_pkg::FPIS_OP_INS;
    end else if (opcd == fpis_pkg::OPC_SUBI) begin
      op_o = fpis_pkg::FPIS_OP_SUB;
    end else if (opcd == fpis_pkg::OPC_SUBI_REC) begin
      op_o = fpis_pkg::FPIS_OP_SUBR;
    end
  end

  // Result path: the insert keeps the target and replaces one bit only.
  always_comb begin
    result_o = tgt_i;
    carry_o  = sum[32];
    if (op_o == fpis_pkg::FPIS_OP_INS) begin
      result_o = tgt_i;
      result_o[5'd31 - amount] = src_i[31];
    end else if (op_o != fpis_pkg::FPIS_OP_NONE) begin
      result_o = sum[31:0];
    end
  end

  // Signed compare against zero: LT, GT, EQ, SO from the exception register.
  assign cr0_o = {result_o[31], ~result_o[31] & (|result_o), ~(|result_o), so_i};
endmodule
`default_nettype wire

// ===== src/fpis_top.sv
// Wishbone-attached fixed-point insert-bit and immediate subtract slice.
// Overview of operation
// - Insert source top bit at rotated amount.
// - Decode opcode 31, extended 537, register fields.
// - Record flag updates condition field zero.
// - Opcode 12 adds sign-extended immediate.
// - Opcode 12 sets carry, not condition field.
// - Opcode 13 performs the same addition.
// - Opcode 13 sets carry and condition field.
`timescale 1ns/100ps
`default_nettype none
module fpis_top (
  input  wire logic        CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [3:0]  ADR_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic [31:0] DAT_I,
  output logic      [31:0] DAT_O,
  output logic             ACK_O,
  input  wire logic        SO_I,
  output logic      [31:0] RESULT_O,
  output logic             CARRY_O,
  output logic      [3:0]  CR0_O,
  output logic             RESULT_WE_O,
  output logic             CARRY_WE_O,
  output logic             CR0_WE_O
);
  logic [31:0] insn_ff;
  logic [31:0] src_ff;
  logic [31:0] amt_ff;
  logic [31:0] tgt_ff;
  logic        go_ff;
  logic        so_ff;
  logic        so_sync_ff;
  logic        ill_ff;
  logic [31:0] nxt_result;
  logic        nxt_carry;
  logic [3:0]  nxt_cr0;
  logic        rec;
  fpis_pkg::fpis_op_e op;
  logic        wr_stb;
  logic        rd_stb;

  // Byte-lane merge used by every writable register.
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] dat,
                                             input logic [3:0] sel);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) m[i*8 +: 8] = dat[i*8 +: 8];
    end
    return m;
  endfunction

  assign wr_stb = CYC_I & STB_I & WE_I & ~ACK_O;
  assign rd_stb = CYC_I & STB_I & ~WE_I & ~ACK_O;

  fpis_exec u_exec (
    .insn_i   (insn_ff),
    .src_i    (src_ff),
    .amt_i    (amt_ff),
    .tgt_i    (tgt_ff),
    .so_i     (so_ff),
    .op_o     (op),
    .result_o (nxt_result),
    .carry_o  (nxt_carry),
    .cr0_o    (nxt_cr0),
    .rec_o    (rec)
  );

  // Summary overflow comes from the exception register elsewhere, so it is synchronised.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      so_sync_ff <= 1'b0;
      so_ff      <= 1'b0;
    end else begin
      so_sync_ff <= SO_I;
      so_ff      <= so_sync_ff;
    end
  end

  // Operand registers; a write to the target word launches execution next cycle.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      insn_ff <= fpis_pkg::RESET_WORD;
      src_ff  <= fpis_pkg::RESET_WORD;
      amt_ff  <= fpis_pkg::RESET_WORD;
      tgt_ff  <= fpis_pkg::RESET_WORD;
      go_ff   <= 1'b0;
    end else begin
      go_ff <= 1'b0;
      if (wr_stb) begin
        unique case (ADR_I)
          fpis_pkg::ADDR_INSN: insn_ff <= lane_merge(insn_ff, DAT_I, SEL_I);
          fpis_pkg::ADDR_SRC:  src_ff  <= lane_merge(src_ff, DAT_I, SEL_I);
          fpis_pkg::ADDR_AMT:  amt_ff  <= lane_merge(amt_ff, DAT_I, SEL_I);
          fpis_pkg::ADDR_RESULT: begin
            tgt_ff <= lane_merge(tgt_ff, DAT_I, SEL_I);
            go_ff  <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end

  // Writeback: each destination updates only under the strobes the operation allows.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      RESULT_O    <= fpis_pkg::RESET_WORD;
      CARRY_O     <= 1'b0;
      CR0_O       <= 4'h0;
      RESULT_WE_O <= 1'b0;
      CARRY_WE_O  <= 1'b0;
      CR0_WE_O    <= 1'b0;
      ill_ff      <= 1'b0;
    end else begin
      RESULT_WE_O <= 1'b0;
      CARRY_WE_O  <= 1'b0;
      CR0_WE_O    <= 1'b0;
      if (go_ff) begin
        ill_ff <= (op == fpis_pkg::FPIS_OP_NONE);
        if (op != fpis_pkg::FPIS_OP_NONE) begin
          RESULT_O    <= nxt_result;
          RESULT_WE_O <= 1'b1;
        end
        // Insert leaves carry alone; both subtracts write it.
        if (op == fpis_pkg::FPIS_OP_SUB || op == fpis_pkg::FPIS_OP_SUBR) begin
          CARRY_O    <= nxt_carry;
          CARRY_WE_O <= 1'b1;
        end
        if (op == fpis_pkg::FPIS_OP_SUBR || (op == fpis_pkg::FPIS_OP_INS && rec)) begin
          CR0_O    <= nxt_cr0;
          CR0_WE_O <= 1'b1;
        end
      end
    end
  end

  // Single-wait-state acknowledge; reads return the result, the status word, or zero at any other address.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ACK_O <= 1'b0;
      DAT_O <= fpis_pkg::RESET_WORD;
    end else begin
      ACK_O <= (wr_stb | rd_stb);
      if (rd_stb) begin
        DAT_O <= 32'h0000_0000;
        if (ADR_I == fpis_pkg::ADDR_RESULT) begin
          DAT_O <= RESULT_O;
        end else if (ADR_I == fpis_pkg::ADDR_STATUS) begin
          DAT_O[fpis_pkg::ST_SO]  <= CR0_O[0];
          DAT_O[fpis_pkg::ST_EQ]  <= CR0_O[1];
          DAT_O[fpis_pkg::ST_GT]  <= CR0_O[2];
          DAT_O[fpis_pkg::ST_LT]  <= CR0_O[3];
          DAT_O[fpis_pkg::ST_CA]  <= CARRY_O;
          DAT_O[fpis_pkg::ST_ILL] <= ill_ff;
        end
      end
    end
  end

  // Checks of writeback and acknowledge behaviour.
  property p_ins_no_carry;
    @(posedge CLK_I) disable iff (!RST_N_I)
      (go_ff && op == fpis_pkg::FPIS_OP_INS) |=> !CARRY_WE_O;
  endproperty
  a_ins_no_carry: assert property (p_ins_no_carry) else $error("insert wrote carry");

  property p_sub_no_cr0;
    @(posedge CLK_I) disable iff (!RST_N_I)
      (go_ff && op == fpis_pkg::FPIS_OP_SUB) |=> CARRY_WE_O && !CR0_WE_O;
  endproperty
  a_sub_no_cr0: assert property (p_sub_no_cr0) else $error("subtract strobes wrong");

  property p_subr_both;
    @(posedge CLK_I) disable iff (!RST_N_I)
      (go_ff && op == fpis_pkg::FPIS_OP_SUBR) |=> CARRY_WE_O && CR0_WE_O;
  endproperty
  a_subr_both: assert property (p_subr_both) else $error("recording subtract strobes");

  property p_ins_rec;
    @(posedge CLK_I) disable iff (!RST_N_I)
      (go_ff && op == fpis_pkg::FPIS_OP_INS) |=> (CR0_WE_O == $past(rec));
  endproperty
  a_ins_rec: assert property (p_ins_rec) else $error("record flag ignored");

  property p_sub_value;
    @(posedge CLK_I) disable iff (!RST_N_I)
      (go_ff && op == fpis_pkg::FPIS_OP_SUB) |=>
        RESULT_O == $past(tgt_ff) + {{16{$past(insn_ff[15])}}, $past(insn_ff[15:0])};
  endproperty
  a_sub_value: assert property (p_sub_value) else $error("subtract sum wrong");

  property p_ins_bit;
    @(posedge CLK_I) disable iff (!RST_N_I)
      (go_ff && op == fpis_pkg::FPIS_OP_INS) |=>
        RESULT_O[5'd31 - $past(amt_ff[4:0])] == $past(src_ff[31]);
  endproperty
  a_ins_bit: assert property (p_ins_bit) else $error("inserted bit wrong");

  property p_eq_flag;
    @(posedge CLK_I) disable iff (!RST_N_I)
      CR0_WE_O |-> (CR0_O[1] == (RESULT_O == 32'h0000_0000)) && (CR0_O[3] == RESULT_O[31]);
  endproperty
  a_eq_flag: assert property (p_eq_flag) else $error("flag mismatch");

  property p_ack_one;
    @(posedge CLK_I) disable iff (!RST_N_I)
      ACK_O |=> !ACK_O;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack held");

  c_ins: cover property (@(posedge CLK_I) go_ff && op == fpis_pkg::FPIS_OP_INS && rec);
  c_sub: cover property (@(posedge CLK_I) go_ff && op == fpis_pkg::FPIS_OP_SUB);
  c_subr: cover property (@(posedge CLK_I) go_ff && op == fpis_pkg::FPIS_OP_SUBR);
endmodule
`default_nettype wire

// ===== bench/fpis_wb_model.sv
// Write-back model of the pipeline side: exception register and target register.
`timescale 1ns/100ps
`default_nettype none
module fpis_wb_model (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        so_set_i,
  input  wire logic        result_we_i,
  input  wire logic [31:0] result_i,
  input  wire logic        carry_we_i,
  input  wire logic        carry_i,
  output logic             so_o,
  output logic             ca_o,
  output logic      [31:0] gpr_o
);
  // Summary overflow is a level of the exception register, set at the bench's request.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      so_o <= 1'b0;
    end else begin
      so_o <= so_set_i;
    end
  end
  // Carry and target change only on their own strobes, so a stray strobe shows up.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ca_o  <= 1'b0;
      gpr_o <= 32'h0000_0000;
    end else begin
      if (carry_we_i) begin
        ca_o <= carry_i;
      end
      if (result_we_i) begin
        gpr_o <= result_i;
      end
    end
  end
endmodule
`default_nettype wire

// ===== bench/fpis_top_tb.sv
// Self-checking bench for the insert-bit and immediate subtract slice.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin num_errors++; \
  $display("MISMATCH %0t %s", $time, "value differs"); end end
module fpis_top_tb;
  logic        clk, rst_n, cyc, stb, we, so_set, ack, rwe, cwe, crwe, ca, so, xca;
  logic [3:0]  adr, cr0, sel;
  logic [31:0] wdat, rdat, res, gpr, seed, rd;
  logic [39:0] expq[$];
  logic [39:0] e;
  int          num_errors = 0;
  int          checks = 0;
  fpis_top i_fpis_top (.CLK_I(clk), .RST_N_I(rst_n), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
    .ADR_I(adr), .SEL_I(sel), .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack), .SO_I(so),
    .RESULT_O(res), .CARRY_O(ca), .CR0_O(cr0), .RESULT_WE_O(rwe), .CARRY_WE_O(cwe),
    .CR0_WE_O(crwe));
  fpis_wb_model i_fpis_wb_model (.clk_i(clk), .rst_n_i(rst_n), .so_set_i(so_set),
    .result_we_i(rwe), .result_i(res), .carry_we_i(cwe), .carry_i(ca), .so_o(so),
    .ca_o(xca), .gpr_o(gpr));
  // Free-running 20 MHz clock.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Expected word: strobes, carry, field zero and result; unwritten parts read as zero.
  function automatic logic [39:0] ex(logic [31:0] r, logic v, logic w, logic c, logic rc);
    logic [3:0] f;
    f = {r[31], !r[31] && r != 32'h0, r == 32'h0, v};
    return {1'b1, w, c & w, rc, rc ? f : 4'h0, r};
  endfunction
  // Classic cycle; ack and read data are taken at the rising edge, before that edge's update.
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic run(input logic [31:0] i, s, a, t, input logic v, input logic [39:0] x);
    so_set <= v;
    wb(1'b1, fpis_pkg::ADDR_INSN, i);
    wb(1'b1, fpis_pkg::ADDR_SRC, s);
    wb(1'b1, fpis_pkg::ADDR_AMT, a);
    if (x[39]) expq.push_back(x);
    wb(1'b1, fpis_pkg::ADDR_RESULT, t);
  endtask
  // Any strobe takes the oldest expectation; a strobe with none pending is a fault.
  always @(negedge clk) begin
    if ((rwe | cwe | crwe) !== 1'b0) begin
      if (expq.size() == 0) `CHK(1'b0, 1'b1)
      else begin
        e = expq.pop_front();
        `CHK({rwe, cwe, cwe & ca, crwe, crwe ? cr0 : 4'h0, res}, e)
      end
    end
  end
  task automatic give_verdict();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Watchdog far beyond the roughly 1300 cycles the sequence needs.
  initial begin
    #2000000;
    num_errors++;
    give_verdict();
  end
  // Main sequence: subtracts with boundaries, inserts at every amount, refusals.
  initial begin
    logic [31:0] x, t, r;
    logic [32:0] sm;
    logic [15:0] m;
    {cyc, stb, we, adr, wdat, so_set, rst_n} = '0;
    sel = 4'hf;
    seed = 32'h6b381c59;
    repeat (5) @(posedge clk);
    `CHK({rwe, cwe, crwe, ack, res}, 36'h0)
    rst_n <= 1'b1;
    for (int k = 0; k < 40; k++) begin
      x = rnd();
      t = rnd();
      m = (k == 2) ? 16'h8000 : (k == 3) ? 16'hf800 : (k == 5) ? 16'h7fff : x[15:0];
      t = (k == 2) ? 32'h0 : (k == 3) ? 32'h0000_0800 : (k == 5) ? 32'h7fff_ffff : t;
      sm = {1'b0, t} + {1'b0, {16{m[15]}}, m};
      run({5'h06, k[0], x[25:16], m}, rnd(), rnd(), t, x[31],
        ex(sm[31:0], x[31], 1'b1, sm[32], k[0]));
    end
    wb(1'b0, fpis_pkg::ADDR_STATUS, 32'h0);
    `CHK(rd[fpis_pkg::ST_CA], sm[32])
    `CHK(rd[3:0], {sm[31], !sm[31] && sm[31:0] != 32'h0, sm[31:0] == 32'h0, x[31]})
    wb(1'b0, fpis_pkg::ADDR_RESULT, 32'h0);
    `CHK(rd, sm[31:0])
    for (int k = 0; k < 64; k++) begin
      x = rnd();
      t = rnd();
      r = t;
      r[31 - k[4:0]] = x[31];
      run({fpis_pkg::OPC_EXT, x[25:11], fpis_pkg::XO_INSERT_BIT, k[5]}, x,
        {rnd() & 32'hffff_ffe0} | {27'h0, k[4:0]}, t, x[0], ex(r, x[0], 1'b0, 1'b0, k[5]));
    end
    `CHK(xca, sm[32])
    run({fpis_pkg::OPC_EXT, 15'h0, 10'h218, 1'b0}, 32'h0, 32'h0, 32'h0, 1'b0, 40'h0);
    wb(1'b0, fpis_pkg::ADDR_STATUS, 32'h0);
    `CHK(rd[fpis_pkg::ST_ILL], 1'b1)
    `CHK(gpr, r)
    wb(1'b0, 4'h2, 32'h0);
    `CHK(rd, 32'h0)
    // Byte lanes: only the low byte of the immediate is rewritten before launch.
    wb(1'b1, fpis_pkg::ADDR_INSN, {fpis_pkg::OPC_SUBI, 10'h0, 16'h1234});
    sel <= 4'h1;
    wb(1'b1, fpis_pkg::ADDR_INSN, 32'h0000_00ff);
    sel <= 4'hf;
    expq.push_back(ex(32'h0000_22ff, 1'b0, 1'b1, 1'b0, 1'b0));
    wb(1'b1, fpis_pkg::ADDR_RESULT, 32'h0000_1000);
    repeat (3) @(posedge clk);
    `CHK(expq.size() == 0, 1'b1)
    give_verdict();
  end
endmodule
`default_nettype wire
